// ---- uerr_far_end.sv ----
// far usb party: sends faulty packets and answers after a chosen delay
`timescale 1ns/1ns
`default_nettype none
module uerr_far_end (
  input wire logic clock_i, // system clock
  input wire logic rst_i, // async reset
  input wire logic go_i, // start one event
  input wire logic [3:0] code_i, // which fault to show
  input wire logic [7:0] dly_i, // answer delay after eop
  output logic [9:0] ev_o, // one-hot fault pulses
  output logic idle_o, // line idle
  output logic resp_o // answer starts
);
  logic [7:0] cnt_q;
  // fault pulse one cycle after the command
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i) ev_o <= 10'h0;
    else ev_o <= go_i ? (10'h1 << code_i) : 10'h0;
  end
  // answer counter: prompt or slow reply after end of packet
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i) cnt_q <= 8'h0;
    else if (go_i && code_i == 4'h4) cnt_q <= dly_i;
    else if (cnt_q != 8'h0) cnt_q <= cnt_q - 8'h1;
  end
  assign resp_o = cnt_q == 8'h1;
  assign idle_o = !resp_o; // line busy only while answering
endmodule
`default_nettype wire

// ---- uerr_pkg.sv ----
// constants for the usb error flag and transaction status block
package uerr_pkg;
  // register offsets (byte addresses on the plain register port)
  localparam logic [7:0] ERR_FLAG_OFS = 8'h00;
  localparam logic [7:0] ERR_EN_OFS = 8'h04;
  localparam logic [7:0] STAT_OFS = 8'h08;
  localparam logic [7:0] MAIN_IRQ_OFS = 8'h0c;
  localparam logic [7:0] MAIN_IRQ_EN_OFS = 8'h10;
  localparam logic [7:0] CTRL_OFS = 8'h14;
  // error flag bit positions
  localparam int BIT_STUFF_BIT = 7;
  localparam int BUF_ADDR_BIT = 6;
  localparam int MEM_ACCESS_BIT = 5;
  localparam int TURNAROUND_BIT = 4;
  localparam int PARTIAL_BYTE_BIT = 3;
  localparam int DATA_CRC_BIT = 2;
  localparam int TOKEN_CRC_EOF_BIT = 1;
  localparam int PACKET_ID_BIT = 0;
  localparam int NUM_ERR = 8;
  // main interrupt register fields
  localparam int TOKEN_DONE_BIT = 3;
  localparam int ERR_SUMMARY_BIT = 1;
  // control register fields
  localparam int HOST_MODE_BIT = 0;
  // status register fields
  localparam int STAT_EP_LSB = 4;
  localparam int STAT_DIR_BIT = 3;
  localparam int STAT_BANK_BIT = 2;
  localparam int STAT_ENTRY_W = 6;
  localparam int STAT_DEPTH = 4;
  // reset values
  localparam logic [7:0] ERR_RESET = 8'h00;
  localparam logic [7:0] EN_RESET = 8'h00;
  // turnaround timing: 16 full-speed bit times at 12 Mbit/s
  localparam int TURNAROUND_BIT_TIMES = 16;
  localparam int CLK_HZ = 50000000;
  localparam int BIT_HZ = 12000000;
  localparam int TURNAROUND_CYCLES = (TURNAROUND_BIT_TIMES * CLK_HZ + BIT_HZ - 1) / BIT_HZ;
endpackage

// ---- uerr_stat_fifo.sv ----
// four-entry transaction status fifo with head presented combinationally
`timescale 1ns/1ns
`default_nettype none
module uerr_stat_fifo #(
  parameter int WIDTH = 6,
  parameter int DEPTH = 4
) (
  input wire logic clock_i, // system clock
  input wire logic rst_i, // async reset, active high
  input wire logic push_i, // write one entry
  input wire logic [WIDTH-1:0] push_data_i, // entry to write
  input wire logic pop_i, // drop head entry
  output logic [WIDTH-1:0] head_o, // head entry
  output logic empty_o, // no entries held
  output logic full_o, // all entries held
  output logic [$clog2(DEPTH):0] count_o // entries held
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_q;
  logic [PW-1:0] rd_q;
  logic [PW:0] cnt_q;
  logic do_push;
  logic do_pop;

  // a push into a full fifo is dropped unless a pop frees a slot in the same cycle; pop only when non-empty
  assign do_pop = pop_i && (cnt_q != '0);
  assign do_push = push_i && ((cnt_q != DEPTH[PW:0]) || do_pop);

  // entry storage
  always_ff @(posedge clock_i)
  begin
    if (do_push)
    begin
      mem_q[wr_q] <= push_data_i;
    end
  end

  // pointers and fill count
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (do_push)
      begin
        wr_q <= wr_q + 1'b1;
      end
      if (do_pop)
      begin
        rd_q <= rd_q + 1'b1;
      end
      if (do_push && !do_pop)
      begin
        cnt_q <= cnt_q + 1'b1;
      end
      else if (do_pop && !do_push)
      begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  assign head_o = (cnt_q == '0) ? '0 : mem_q[rd_q];
  assign empty_o = (cnt_q == '0);
  assign full_o = (cnt_q == DEPTH[PW:0]);
  assign count_o = cnt_q;
endmodule
`default_nettype wire

// ---- uerr_top.sv ----
// usb error flags, error enables, summary interrupt and transaction status
// Functional notes
// - bit 7 flag set when a packet is rejected for bit stuffing
// - bit 6 flag set on invalid descriptor table or buffer address
// - bit 5 flag set on bus overflow, underflow or truncated packet
// - bit 4 flag set after over 16 idle bit times without response
// - bit 3 flag set when data field is not whole bytes
// - bit 2 flag set and data packet rejected on crc16 failure
// - peripheral mode: bit 1 flags token crc5 failure
// - host mode: bit 1 flags frame countdown zero during activity
// - bit 0 flag set when the packet id complement check fails
// - flags reset zero, hardware sets, write one clears, zero leaves
// - read-write enable per flag, reset zero, bit 1 mode dependent
// - enabled errors reach irq line only with summary enable bit 1
// - bits 31-8 of three registers and status bits 1-0 read zero
// - status bits 7-4 give last endpoint number in binary
// - status bit 3 is one for transmit, zero for receive
// - status bit 2 is one for odd bank, zero for even
// - status entries kept in a four-deep fifo, head readable
// - clearing token-complete pops the status fifo head
// - token-complete flag at main interrupt bit 3 set per token
// - summary error flag set only by enabled error flags
`timescale 1ns/1ns
`default_nettype none
module uerr_top #(
  parameter int TURNAROUND_CYCLES = uerr_pkg::TURNAROUND_CYCLES,
  parameter int STAT_DEPTH = uerr_pkg::STAT_DEPTH
) (
  input wire logic clock_i, // system clock, 50 MHz
  input wire logic rst_i, // async reset, active high
  // register port
  input wire logic [7:0] addr_i, // byte address
  input wire logic [31:0] wdata_i, // write data
  input wire logic wr_i, // write strobe
  input wire logic rd_i, // read strobe
  output logic [31:0] rdata_o, // read data, cycle after rd_i
  // packet engine events, one-cycle pulses
  input wire logic bit_stuff_err_i, // packet rejected for bit stuffing
  input wire logic buf_addr_err_i, // invalid descriptor or buffer address
  input wire logic mem_late_grant_i, // bus grant too late, over/underflow
  input wire logic mem_truncate_i, // buffer too small, packet truncated
  input wire logic partial_byte_err_i, // data field not whole bytes
  input wire logic data_crc_fail_i, // crc16 check failed
  input wire logic token_crc_fail_i, // crc5 check failed on token
  input wire logic pid_check_fail_i, // pid complement check failed
  // link timing inputs
  input wire logic eop_i, // end of packet seen, pulse
  input wire logic bus_idle_i, // line is idle this cycle
  input wire logic resp_seen_i, // expected response began
  input wire logic frame_count_zero_i, // frame start countdown hit zero
  input wire logic xfer_active_i, // transmit or receive in progress
  // transaction completion
  input wire logic token_done_i, // token processing finished, pulse
  input wire logic [3:0] done_endpoint_i, // endpoint of finished token
  input wire logic done_tx_i, // 1 transmit, 0 receive
  input wire logic done_odd_i, // 1 odd bank, 0 even bank
  // outputs
  output logic data_reject_o, // data packet rejected, pulse
  output logic host_mode_o, // host mode selected
  output logic controller_irq_line_o, // error interrupt line
  output logic stat_full_o // status fifo full
);
  logic [7:0] error_flag_q;
  logic [7:0] error_enable_q;
  logic [7:0] err_event;
  logic token_done_flag_q;
  logic error_summary_enable_q;
  logic host_mode_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  // turnaround watchdog states, one-hot
  typedef enum logic [1:0] {
    TA_IDLE = 2'b01,
    TA_WAIT = 2'b10
  } uerr_ta_state_e;
  uerr_ta_state_e ta_state_q;
  uerr_ta_state_e ta_state_d;
  logic [15:0] idle_cnt_q;
  logic wait_resp;
  logic timeout_evt;
  logic data_reject_q;
  logic stat_pop;
  logic stat_empty;
  logic [uerr_pkg::STAT_ENTRY_W-1:0] stat_head;
  logic [uerr_pkg::STAT_ENTRY_W-1:0] stat_push_data;
  logic [$clog2(STAT_DEPTH):0] stat_count;
  logic wr_err;
  logic wr_en;
  logic wr_mirq;
  logic wr_mien;
  logic wr_ctrl;
  logic clr_token_done;
  logic error_summary_flag;
  logic [31:0] err_flag_word;
  logic [31:0] err_en_word;
  logic [31:0] stat_word;
  logic [31:0] main_irq_word;
  logic [31:0] main_irq_en_word;
  logic [31:0] ctrl_word;

  // write decodes
  assign wr_err = wr_i && (addr_i == uerr_pkg::ERR_FLAG_OFS);
  assign wr_en = wr_i && (addr_i == uerr_pkg::ERR_EN_OFS);
  assign wr_mirq = wr_i && (addr_i == uerr_pkg::MAIN_IRQ_OFS);
  assign wr_mien = wr_i && (addr_i == uerr_pkg::MAIN_IRQ_EN_OFS);
  assign wr_ctrl = wr_i && (addr_i == uerr_pkg::CTRL_OFS);
  assign clr_token_done = wr_mirq && wdata_i[uerr_pkg::TOKEN_DONE_BIT];

  // next watchdog state: armed by an eop, disarmed by traffic or a timeout
  always_comb
  begin
    ta_state_d = ta_state_q;
    case (ta_state_q)
      TA_IDLE:
      begin
        if (eop_i)
        begin
          ta_state_d = TA_WAIT;
        end
      end
      TA_WAIT:
      begin
        if (eop_i)
        begin
          ta_state_d = TA_WAIT;
        end
        else if (resp_seen_i || !bus_idle_i || timeout_evt)
        begin
          ta_state_d = TA_IDLE;
        end
      end
      default: ta_state_d = TA_IDLE;
    endcase
  end

  // watchdog state register
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ta_state_q <= TA_IDLE;
    end
    else
    begin
      ta_state_q <= ta_state_d;
    end
  end
  assign wait_resp = (ta_state_q == TA_WAIT);

  // idle cycles counted while waiting; a new eop restarts the count
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      idle_cnt_q <= '0;
    end
    else if (eop_i || (ta_state_d != TA_WAIT))
    begin
      idle_cnt_q <= '0;
    end
    else
    begin
      idle_cnt_q <= idle_cnt_q + 16'h0001;
    end
  end
  // fires once the idle span exceeds the turnaround window
  assign timeout_evt = wait_resp && bus_idle_i && !resp_seen_i && !eop_i
    && (idle_cnt_q >= TURNAROUND_CYCLES[15:0]);

  // hardware error events by flag position
  always_comb
  begin
    err_event = 8'h00;
    err_event[uerr_pkg::BIT_STUFF_BIT] = bit_stuff_err_i;
    err_event[uerr_pkg::BUF_ADDR_BIT] = buf_addr_err_i;
    err_event[uerr_pkg::MEM_ACCESS_BIT] = mem_late_grant_i || mem_truncate_i;
    err_event[uerr_pkg::TURNAROUND_BIT] = timeout_evt;
    err_event[uerr_pkg::PARTIAL_BYTE_BIT] = partial_byte_err_i;
    err_event[uerr_pkg::DATA_CRC_BIT] = data_crc_fail_i;
    // bit 1 means token crc in peripheral mode, frame end in host mode
    err_event[uerr_pkg::TOKEN_CRC_EOF_BIT] = host_mode_q
      ? (frame_count_zero_i && xfer_active_i)
      : token_crc_fail_i;
    err_event[uerr_pkg::PACKET_ID_BIT] = pid_check_fail_i;
  end

  // sticky error flags: write one clears, a new event wins over a clear
  genvar gi;
  generate
    for (gi = 0; gi < uerr_pkg::NUM_ERR; gi++)
    begin : g_flag
      always_ff @(posedge clock_i or posedge rst_i)
      begin
        if (rst_i)
        begin
          error_flag_q[gi] <= uerr_pkg::ERR_RESET[gi];
        end
        else if (err_event[gi])
        begin
          error_flag_q[gi] <= 1'b1;
        end
        else if (wr_err && wdata_i[gi])
        begin
          error_flag_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // data packet rejection pulse on crc16 failure
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      data_reject_q <= 1'b0;
    end
    else
    begin
      data_reject_q <= data_crc_fail_i;
    end
  end

  // error enables, summary enable and mode control
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      error_enable_q <= uerr_pkg::EN_RESET;
      error_summary_enable_q <= 1'b0;
      host_mode_q <= 1'b0;
    end
    else
    begin
      if (wr_en)
      begin
        error_enable_q <= wdata_i[7:0];
      end
      if (wr_mien)
      begin
        error_summary_enable_q <= wdata_i[uerr_pkg::ERR_SUMMARY_BIT];
      end
      if (wr_ctrl)
      begin
        host_mode_q <= wdata_i[uerr_pkg::HOST_MODE_BIT];
      end
    end
  end

  // summary flag follows only unmasked error flags
  assign error_summary_flag = |(error_flag_q & error_enable_q);
  // the line needs the summary enable as well
  assign controller_irq_line_o = error_summary_flag && error_summary_enable_q;

  // token-complete flag: set per token, refilled while fifo holds entries
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      token_done_flag_q <= 1'b0;
    end
    else if (token_done_i)
    begin
      token_done_flag_q <= 1'b1;
    end
    else if (clr_token_done && token_done_flag_q)
    begin
      token_done_flag_q <= (stat_count > 1);
    end
    else if (!stat_empty)
    begin
      token_done_flag_q <= 1'b1;
    end
  end

  // pop only when software clears a set flag
  assign stat_pop = clr_token_done && token_done_flag_q;
  assign stat_push_data = {done_endpoint_i, done_tx_i, done_odd_i};

  uerr_stat_fifo #(
    .WIDTH(uerr_pkg::STAT_ENTRY_W),
    .DEPTH(STAT_DEPTH)
  ) u_stat_fifo (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .push_i(token_done_i),
    .push_data_i(stat_push_data),
    .pop_i(stat_pop),
    .head_o(stat_head),
    .empty_o(stat_empty),
    .full_o(stat_full_o),
    .count_o(stat_count)
  );

  // register read words; unimplemented bits read zero
  always_comb
  begin
    err_flag_word = 32'h0000_0000;
    err_en_word = 32'h0000_0000;
    stat_word = 32'h0000_0000;
    main_irq_word = 32'h0000_0000;
    main_irq_en_word = 32'h0000_0000;
    ctrl_word = 32'h0000_0000;
    err_flag_word[7:0] = error_flag_q;
    err_en_word[7:0] = error_enable_q;
    stat_word[7:uerr_pkg::STAT_EP_LSB] = stat_head[5:2];
    stat_word[uerr_pkg::STAT_DIR_BIT] = stat_head[1];
    stat_word[uerr_pkg::STAT_BANK_BIT] = stat_head[0];
    main_irq_word[uerr_pkg::TOKEN_DONE_BIT] = token_done_flag_q;
    main_irq_word[uerr_pkg::ERR_SUMMARY_BIT] = error_summary_flag;
    main_irq_en_word[uerr_pkg::ERR_SUMMARY_BIT] = error_summary_enable_q;
    ctrl_word[uerr_pkg::HOST_MODE_BIT] = host_mode_q;
  end

  // read mux; unmapped addresses read zero
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    case (addr_i)
      uerr_pkg::ERR_FLAG_OFS: rdata_d = err_flag_word;
      uerr_pkg::ERR_EN_OFS: rdata_d = err_en_word;
      uerr_pkg::STAT_OFS: rdata_d = stat_word;
      uerr_pkg::MAIN_IRQ_OFS: rdata_d = main_irq_word;
      uerr_pkg::MAIN_IRQ_EN_OFS: rdata_d = main_irq_en_word;
      uerr_pkg::CTRL_OFS: rdata_d = ctrl_word;
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  // read data register, valid only the cycle after a read
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rdata_q <= 32'h0000_0000;
    end
    else if (rd_i)
    begin
      rdata_q <= rdata_d;
    end
    else
    begin
      rdata_q <= 32'h0000_0000;
    end
  end

  assign rdata_o = rdata_q;
  assign data_reject_o = data_reject_q;
  assign host_mode_o = host_mode_q;
endmodule
`default_nettype wire

// ---- uerr_top_properties.sv ----
// concurrent checks on the ports of the usb error flag block
`timescale 1ns/1ns
`default_nettype none
module uerr_top_chk (
  input wire logic clock_i, // system clock
  input wire logic rst_i, // async reset
  input wire logic [7:0] addr_i, // byte address
  input wire logic [31:0] wdata_i, // write data
  input wire logic wr_i, // write strobe
  input wire logic rd_i, // read strobe
  input wire logic [31:0] rdata_o, // read data
  input wire logic bit_stuff_err_i, // stuffing fault
  input wire logic data_crc_fail_i, // crc16 fault
  input wire logic token_done_i, // token finished
  input wire logic data_reject_o, // data packet rejected
  input wire logic controller_irq_line_o, // error interrupt
  input wire logic stat_full_o // status fifo full
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // data packet rejection follows a crc16 fault
  property p_reject; data_crc_fail_i |=> data_reject_o; endproperty
  a_reject: assert property (p_reject) else $error("no reject after crc16 fault");
  property p_reject_cause; data_reject_o |-> $past(data_crc_fail_i); endproperty
  a_reject_cause: assert property (p_reject_cause) else $error("reject without crc16 fault");
  // read data bus is quiet outside the answer cycle
  property p_idle_rdata; !$past(rd_i) |-> rdata_o == 32'h0; endproperty
  a_idle_rdata: assert property (p_idle_rdata) else $error("read data outside answer cycle");
  property p_upper_zero; rd_i |=> rdata_o[31:8] == 24'h0; endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper read bits not zero");
  property p_stat_low; rd_i && addr_i == uerr_pkg::STAT_OFS |=> rdata_o[1:0] == 2'h0; endproperty
  a_stat_low: assert property (p_stat_low) else $error("status low bits not zero");
  // a stuffing fault is visible on the next flag read
  property p_flag_seen;
    bit_stuff_err_i ##1 (rd_i && addr_i == uerr_pkg::ERR_FLAG_OFS) |=> rdata_o[7];
  endproperty
  a_flag_seen: assert property (p_flag_seen) else $error("stuffing flag not set");
  // masking all errors or the summary silences the line
  property p_mask_off;
    wr_i && addr_i == uerr_pkg::ERR_EN_OFS && wdata_i[7:0] == 8'h0 |=> !controller_irq_line_o;
  endproperty
  a_mask_off: assert property (p_mask_off) else $error("irq with all errors masked");
  property p_summary_off;
    wr_i && addr_i == uerr_pkg::MAIN_IRQ_EN_OFS && !wdata_i[1] |=> !controller_irq_line_o;
  endproperty
  a_summary_off: assert property (p_summary_off) else $error("irq with summary disabled");
  property p_full_cause; $rose(stat_full_o) |-> $past(token_done_i); endproperty
  a_full_cause: assert property (p_full_cause) else $error("fifo filled without a push");
endmodule
bind uerr_top uerr_top_chk i_chk (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .bit_stuff_err_i(bit_stuff_err_i),
  .data_crc_fail_i(data_crc_fail_i), .token_done_i(token_done_i), .data_reject_o(data_reject_o),
  .controller_irq_line_o(controller_irq_line_o), .stat_full_o(stat_full_o));
`default_nettype wire

// ---- uerr_top_test.sv ----
// self-checking bench for the usb error flag block
`timescale 1ns/1ns
`default_nettype none
module uerr_top_test;
  logic clock_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, go = 0, token_done_i = 0, done_tx_i = 0, done_odd_i = 0;
  logic [7:0] addr_i = 0, dly = 0, e;
  logic [3:0] code = 0, done_endpoint_i = 0;
  logic [31:0] wdata_i = 0, rdata_o, s;
  logic [5:0] ent [5];
  wire logic [9:0] ev;
  wire logic bit_stuff_err_i, buf_addr_err_i, mem_late_grant_i, mem_truncate_i, partial_byte_err_i;
  wire logic data_crc_fail_i, token_crc_fail_i, pid_check_fail_i, eop_i, bus_idle_i, resp_seen_i;
  wire logic frame_count_zero_i, xfer_active_i, data_reject_o, host_mode_o, controller_irq_line_o, stat_full_o;
  int seed = 88674, fail_count = 0, check_count = 0, c;
  assign {frame_count_zero_i, mem_truncate_i, bit_stuff_err_i, buf_addr_err_i, mem_late_grant_i, eop_i,
    partial_byte_err_i, data_crc_fail_i, token_crc_fail_i, pid_check_fail_i} = ev;
  logic frame_busy = 1'b1;
  assign xfer_active_i = frame_count_zero_i && frame_busy;
  uerr_far_end i_far (.clock_i, .rst_i, .go_i(go), .code_i(code), .dly_i(dly), .ev_o(ev), .idle_o(bus_idle_i),
    .resp_o(resp_seen_i));
  uerr_top #(.TURNAROUND_CYCLES(4)) i_dut (.clock_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .bit_stuff_err_i, .buf_addr_err_i, .mem_late_grant_i, .mem_truncate_i, .partial_byte_err_i,
    .data_crc_fail_i, .token_crc_fail_i, .pid_check_fail_i, .eop_i, .bus_idle_i, .resp_seen_i,
    .frame_count_zero_i, .xfer_active_i, .token_done_i, .done_endpoint_i, .done_tx_i, .done_odd_i,
    .data_reject_o, .host_mode_o, .controller_irq_line_o, .stat_full_o);
  // 50 MHz clock
  initial
  begin
    forever #10 clock_i = ~clock_i;
  end
  // flag bit that a far-side event code should set
  function automatic logic [7:0] flag_of(input int k);
    return k < 8 ? 8'h1 << k : (k == 8 ? 8'h20 : 8'h02);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    addr_i <= a; wdata_i <= d; wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock_i);
    addr_i <= a; rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, exp);
  endtask
  task automatic fire(input int k, input logic [7:0] d);
    @(posedge clock_i);
    go <= 1'b1; code <= k[3:0]; dly <= d;
    @(posedge clock_i);
    go <= 1'b0;
    repeat (16) @(posedge clock_i);
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // watchdog
  initial
  begin
    repeat (20000) @(posedge clock_i);
    fail_count++;
    complete_run;
  end
  initial
  begin
    repeat (20) @(posedge clock_i);
    rst_i <= 1'b0;
    rchk(8'h00, 0);
    rchk(8'h04, 0);
    rchk(8'h08, 0);
    wr(8'h04, 32'hffffffff);
    rchk(8'h04, 32'hff);
    wr(8'h10, 32'h2);
    fire(4, 2);
    rchk(8'h00, 0);
    // fault codes 0 to 8 each set their flag; zero writes keep it, one clears
    for (c = 0; c < 9; c++)
    begin
      fire(c, 10);
      chk(controller_irq_line_o, 1);
      rchk(8'h00, flag_of(c));
      wr(8'h00, {24'h0, ~flag_of(c)});
      rchk(8'h00, flag_of(c));
      wr(8'h00, flag_of(c));
      rchk(8'h00, 0);
    end
    // host mode: bit 1 follows frame end during activity, not token crc
    wr(8'h14, 1);
    #1 chk(host_mode_o, 1);
    fire(1, 0);
    rchk(8'h00, 0);
    frame_busy <= 1'b0;
    fire(9, 0);
    rchk(8'h00, 0);
    frame_busy <= 1'b1;
    fire(9, 0);
    rchk(8'h00, 8'h02);
    wr(8'h14, 0);
    wr(8'h00, 8'hff);
    fire(9, 0);
    rchk(8'h00, 0);
    // flag read straight after a stuffing fault, then masking silences the line
    @(posedge clock_i);
    go <= 1'b1;
    code <= 4'h7;
    @(posedge clock_i);
    go <= 1'b0;
    rchk(8'h00, 8'h80);
    wr(8'h04, 32'h0);
    #1 chk(controller_irq_line_o, 0);
    wr(8'h04, 32'hff);
    wr(8'h10, 32'h0);
    #1 chk(controller_irq_line_o, 0);
    wr(8'h00, 8'hff);
    // random enables and summary enable against random faults
    repeat (16)
    begin
      e = 8'($random(seed));
      s = $random(seed);
      c = {$random(seed)} % 8;
      wr(8'h04, {24'h0, e});
      wr(8'h10, {30'h0, s[0], 1'b0});
      fire(c, 10);
      chk(controller_irq_line_o, |(flag_of(c) & e) & s[0]);
      rchk(8'h0c, {30'h0, |(flag_of(c) & e), 1'b0});
      wr(8'h00, 8'hff);
    end
    wr(8'h20, 8'hff);
    rchk(8'h20, 0);
    // five back-to-back tokens into a four-deep fifo
    for (c = 0; c < 5; c++)
    begin
      ent[c] = 6'($random(seed));
      @(posedge clock_i);
      token_done_i <= 1'b1;
      {done_endpoint_i, done_tx_i, done_odd_i} <= ent[c];
    end
    @(posedge clock_i);
    token_done_i <= 1'b0;
    #1 chk(stat_full_o, 1);
    for (c = 0; c < 4; c++)
    begin
      rchk(8'h0c, 8'h08);
      rchk(8'h08, {ent[c], 2'b0});
      wr(8'h0c, 8'h08);
    end
    rchk(8'h0c, 0);
    rchk(8'h08, 0);
    complete_run;
  end
endmodule
`default_nettype wire
